// >>> logic/list_pointer_pkg.sv
// How it works
// - periodic current pointer at 1Ch, bits 31..4, read-only, reset zero.
// - periodic current pointer holds address of the descriptor being handled now.
// - periodic current pointer starts at the head of this frame's periodic list.
// - periodic current pointer rewritten when a periodic descriptor completes.
// - control head pointer at 20h, bits 31..4, read-only from bus, reset zero.
// - control list walk starts at the control head pointer.
// - control head pointer loaded from communication area during initialization.
// - control current pointer at 24h holds the current control descriptor address.
package list_pointer_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] periodic_current_offset = 8'h1C;
    localparam logic [7:0] control_head_offset     = 8'h20;
    localparam logic [7:0] control_current_offset  = 8'h24;

    localparam int         pointer_lsb             = 4;
    localparam int         pointer_width           = 28;
    localparam logic [27:0] pointer_reset          = 28'h0000000;
    localparam logic [3:0]  reserved_value         = 4'h0;
    localparam logic [31:0] unmapped_value         = 32'h00000000;

    // ****************************************
    // engine update request
    // ****************************************
    typedef struct packed {
        logic        frame_start;
        logic [27:0] frame_list_head;
        logic        periodic_done;
        logic [27:0] periodic_next;
        logic        init_load;
        logic [27:0] hcca_control_head;
        logic        control_start;
        logic        control_done;
        logic [27:0] control_next;
    } engine_update_t;

endpackage

// >>> logic/list_pointer_regs.sv
`timescale 1ns/1ns
module list_pointer_regs
    import list_pointer_pkg::*;
(
    input  wire logic           core_clk_in,
    input  wire logic           rst_in,
    input  wire engine_update_t engine_in,
    input  wire logic           read_strobe_in,
    input  wire logic [7:0]     read_offset_in,
    output logic [31:0]         read_data_out,
    output logic                read_valid_out,
    output logic [31:0]         periodic_current_out,
    output logic [31:0]         control_head_out,
    output logic [31:0]         control_current_out
);

    // ****************************************
    // pointer storage
    // ****************************************
    logic [pointer_width-1:0] periodic_current_pointer;
    logic [pointer_width-1:0] control_head_pointer;
    logic [pointer_width-1:0] control_current_pointer;

    // ****************************************
    // engine request fields
    // ****************************************
    logic                     frame_start;
    logic [pointer_width-1:0] frame_list_head;
    logic                     periodic_done;
    logic [pointer_width-1:0] periodic_next;
    logic                     init_load;
    logic [pointer_width-1:0] area_control_head;
    logic                     control_start;
    logic                     control_done;
    logic [pointer_width-1:0] control_next;

    // ****************************************
    // bus words and read selection
    // ****************************************
    logic [31:0]              periodic_current_word;
    logic [31:0]              control_head_word;
    logic [31:0]              control_current_word;
    logic [31:0]              next_read_data;

    // ****************************************
    // engine request unpacking
    // ****************************************
    always_comb
    begin
        frame_start       = engine_in.frame_start;
        frame_list_head   = engine_in.frame_list_head;
        periodic_done     = engine_in.periodic_done;
        periodic_next     = engine_in.periodic_next;
        init_load         = engine_in.init_load;
        area_control_head = engine_in.hcca_control_head;
        control_start     = engine_in.control_start;
        control_done      = engine_in.control_done;
        control_next      = engine_in.control_next;
    end

    // ****************************************
    // periodic list pointer
    // ****************************************
    // a completed descriptor outranks the frame start load
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            periodic_current_pointer <= pointer_reset;
        end
        else if (periodic_done)
        begin
            periodic_current_pointer <= periodic_next;
        end
        else if (frame_start)
        begin
            periodic_current_pointer <= frame_list_head;
        end
    end

    // ****************************************
    // control list head pointer
    // ****************************************
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_head_pointer <= pointer_reset;
        end
        else if (init_load)
        begin
            control_head_pointer <= area_control_head;
        end
    end

    // ****************************************
    // control list current pointer
    // ****************************************
    // a completed descriptor outranks a fresh walk from the head
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_current_pointer <= pointer_reset;
        end
        else if (control_done)
        begin
            control_current_pointer <= control_next;
        end
        else if (control_start)
        begin
            control_current_pointer <= control_head_pointer;
        end
    end

    // ****************************************
    // bus words, reserved bits forced low
    // ****************************************
    always_comb
    begin
        periodic_current_word                            = unmapped_value;
        periodic_current_word[pointer_lsb+:pointer_width] = periodic_current_pointer;
        periodic_current_word[pointer_lsb-1:0]           = reserved_value;
        control_head_word                                = unmapped_value;
        control_head_word[pointer_lsb+:pointer_width]    = control_head_pointer;
        control_head_word[pointer_lsb-1:0]               = reserved_value;
        control_current_word                             = unmapped_value;
        control_current_word[pointer_lsb+:pointer_width] = control_current_pointer;
        control_current_word[pointer_lsb-1:0]            = reserved_value;
    end

    // ****************************************
    // read decode
    // ****************************************
    // unmapped offsets answer with zero
    always_comb
    begin
        unique case (read_offset_in)
            periodic_current_offset:
            begin
                next_read_data = periodic_current_word;
            end
            control_head_offset:
            begin
                next_read_data = control_head_word;
            end
            control_current_offset:
            begin
                next_read_data = control_current_word;
            end
            default:
            begin
                next_read_data = unmapped_value;
            end
        endcase
    end

    // ****************************************
    // read port
    // ****************************************
    // data holds until the next read
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            read_data_out <= unmapped_value;
        end
        else if (read_strobe_in)
        begin
            read_data_out <= next_read_data;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            read_valid_out <= 1'b0;
        end
        else
        begin
            read_valid_out <= read_strobe_in;
        end
    end

    // ****************************************
    // register mirrors
    // ****************************************
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            periodic_current_out <= unmapped_value;
        end
        else
        begin
            periodic_current_out <= periodic_current_word;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_head_out <= unmapped_value;
        end
        else
        begin
            control_head_out <= control_head_word;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_current_out <= unmapped_value;
        end
        else
        begin
            control_current_out <= control_current_word;
        end
    end

endmodule

// >>> bench/list_pointer_chk.sv
`timescale 1ns/1ns
module list_pointer_chk import list_pointer_pkg::*; (
input wire logic core_clk_in, rst_in, read_strobe_in, read_valid_out,
input wire engine_update_t engine_in, input wire logic [7:0] read_offset_in,
input wire logic [31:0] read_data_out, periodic_current_out, control_head_out,
input wire logic [31:0] control_current_out);
default clocking @(posedge core_clk_in); endclocking
default disable iff (rst_in);
valid_pulse_a: assert property (##1 read_valid_out == $past(read_strobe_in))
else $error("valid");
low_bits_a: assert property (read_data_out[3:0] == 4'h0) else $error("low");
pc_read_a: assert property (read_strobe_in && read_offset_in == 8'h1C
|=> read_data_out == periodic_current_out) else $error("pc");
ch_read_a: assert property (read_strobe_in && read_offset_in == 8'h20
|=> read_data_out == control_head_out) else $error("ch");
cc_read_a: assert property (read_strobe_in && read_offset_in == 8'h24
|=> read_data_out == control_current_out) else $error("cc");
pc_done_a: assert property (engine_in.periodic_done |=> ##1
periodic_current_out[31:4] == $past(engine_in.periodic_next, 2)) else $error("done");
frame_load_a: assert property (engine_in.frame_start && !engine_in.periodic_done |=> ##1
periodic_current_out[31:4] == $past(engine_in.frame_list_head, 2)) else $error("frame");
init_load_a: assert property (engine_in.init_load |=> ##1
control_head_out[31:4] == $past(engine_in.hcca_control_head, 2)) else $error("init");
cc_done_a: assert property (engine_in.control_done |=> ##1
control_current_out[31:4] == $past(engine_in.control_next, 2)) else $error("ccdone");
cc_start_a: assert property (engine_in.control_start && !engine_in.control_done |=> ##1
control_current_out == $past(control_head_out)) else $error("ccstart");
endmodule
bind list_pointer_regs list_pointer_chk chk (.*);

// >>> bench/list_pointer_regs_test.sv
`timescale 1ns/1ns
module list_pointer_regs_test;
import list_pointer_pkg::*;
logic c = 0, r = 1, s = 0, v;
logic [7:0] o = 0;
logic [31:0] d;
engine_update_t e = '0;
int bad_count = 0, n_checks = 0, t = 0;
always #20 c = ~c;
list_pointer_regs dut (.core_clk_in(c), .rst_in(r), .engine_in(e), .read_strobe_in(s),
    .read_offset_in(o), .read_data_out(d), .read_valid_out(v), .periodic_current_out(),
    .control_head_out(), .control_current_out());
task chk(input logic [32:0] a, b);
    n_checks++;
    if (a !== b) begin bad_count++; $display("ERROR %0t saw %h", $time, a); end
endtask
task rd(input logic [7:0] a, input logic [31:0] x);
    s = 1;
    o = a;
    @(negedge c);
    s = 0;
    chk({v, d}, {1'b1, x});
    @(negedge c);
    chk({v, d}, {1'b0, x});
endtask
task pu(input engine_update_t x); e = x; @(negedge c); e = '0; endtask
task report_and_stop;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
task t_reset;
    rd(8'h1C, 0); rd(8'h20, 0); rd(8'h24, 0); rd(8'h2C, 0);
    $display("reset test done");
endtask
task t_walk;
    pu('{frame_start:1, frame_list_head:28'h8000001, default:0});
    rd(8'h1C, 32'h80000010);
    pu('{frame_start:1, periodic_done:1, periodic_next:28'h5A, default:0});
    rd(8'h1C, 32'h5A0);
    pu('{init_load:1, hcca_control_head:28'h3C, default:0});
    rd(8'h20, 32'h3C0);
    pu('{control_start:1, default:0});
    rd(8'h24, 32'h3C0);
    pu('{control_done:1, control_start:1, control_next:28'hA5, default:0});
    rd(8'h24, 32'hA50);
    rd(8'h20, 32'h3C0);
    $display("walk test done");
endtask
task t_rereset;
    r = 1;
    repeat (2) @(negedge c);
    r = 0;
    rd(8'h1C, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    $display("second reset test done");
endtask
initial begin repeat (8) @(negedge c); r = 0; t_reset; t_walk; t_rereset; report_and_stop; end
always @(posedge c) begin t <= t + 1; if (t == 300) begin bad_count++; report_and_stop; end end
endmodule
